/* logic/sprs_pkg.sv */
// Package: constants and state encoding for the stack pointer and return sequencer
package sprs_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int ADDR_WIDTH = 16;
  localparam int DATA_WIDTH = 8;

  // ==========================================================================
  // Fixed address fields and reset values
  // ==========================================================================
  // Page byte forced onto the upper address lines for every stack access
  localparam logic [7:0] STACK_PAGE = 8'h01;
  // Stack pointer after reset: top of the stack page
  localparam logic [7:0] SP_RESET = 8'hff;
  // Program counter after reset; plain default, reset vectors are outside this block
  localparam logic [15:0] PC_RESET = 16'h0000;
  // Bytes pushed by an interrupt entry and by a subroutine call
  localparam int IRQ_STACK_BYTES = 3;
  localparam int CALL_STACK_BYTES = 2;
  // Bus cycles of a return, start cycle included, next fetch excluded
  localparam int RETURN_CYCLES = 6;

  // ==========================================================================
  // Sequencer states
  // ==========================================================================
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_RET_LOOK,
    ST_RET_DEAD,
    ST_RET_LOW,
    ST_RET_HIGH,
    ST_RET_INC,
    ST_CALL_LOW,
    ST_CALL_DEAD,
    ST_CALL_WHIGH,
    ST_CALL_WLOW,
    ST_CALL_HIGH,
    ST_PUSH_LOOK,
    ST_PUSH_WR,
    ST_PULL_LOOK,
    ST_PULL_DEAD,
    ST_PULL_RD
  } sprs_state_type;

  typedef enum logic [1:0] {
    IRQ_IDLE,
    IRQ_WHIGH,
    IRQ_WLOW,
    IRQ_WSTAT
  } sprs_irq_type;

endpackage

/* logic/sprs_stack_pointer.sv */
// Module: eight-bit self-adjusting stack pointer with the fixed stack page
module sprs_stack_pointer
  import sprs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_load,
  input wire logic [7:0] i_load_value,
  input wire logic i_inc,
  input wire logic i_dec,
  output logic [7:0] o_value,
  output logic [15:0] o_stack_addr
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [7:0] sp;
  } sprs_sp_state_type;

  sprs_sp_state_type state_q;
  sprs_sp_state_type state_d;

  // Load wins; no bound check, so the pointer runs freely through the page
  always_comb
  begin
    state_d = state_q;
    if (i_load)
    begin
      state_d.sp = i_load_value;
    end
    else if (i_inc)
    begin
      state_d.sp = state_q.sp + 8'h01;
    end
    else if (i_dec)
    begin
      state_d.sp = state_q.sp - 8'h01;
    end
  end

  // Register stage
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      state_q.sp <= SP_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Page byte is constant, the pointer only ever supplies the low byte
  assign o_value = state_q.sp;
  assign o_stack_addr = {STACK_PAGE, state_q.sp};

endmodule

/* logic/sprs_sequencer.sv */
// Module: bus sequencer for return, call, push, pull and interrupt entry
//
// Contract
// - A return is a one-byte operation: cycle one fetches its opcode and cycle two reads and drops the next byte.
// - Return cycle three puts the stack address out, drops the data and increments the stack pointer.
// - Return cycle four puts the incremented stack address out, loads the low program counter byte and increments again.
// - Return cycle five puts the twice-incremented stack address out and loads the high program counter byte.
// - Return cycle six puts the restored counter out, drops the data and adds one to the counter.
// - Cycle seven fetches the next opcode at the incremented counter, so a return takes six cycles.
// - The stack pointer names the next free location, so a pull increments it first at a cost of one cycle.
// - Every pushed byte decrements the stack pointer and every pulled byte increments it, for program and interrupts alike.
// - The stack pointer is an eight-bit register, so the stack spans at most 256 bytes of one page.
// - Every stack access drives 01 hex on the upper address byte with the pointer on the lower byte.
// - A call uses two bytes of stack and an interrupt entry uses three.
// - The pointer is adjusted without any bound check and wraps around within the stack page.
// - A call saves the address of its own last byte, which the return corrects by adding one.
module sprs_sequencer
  import sprs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_return_op,
  input wire logic i_call_subroutine_op,
  input wire logic i_push_op,
  input wire logic i_pull_op,
  input wire logic i_irq_entry,
  input wire logic i_sp_load,
  input wire logic [7:0] i_sp_value,
  input wire logic [7:0] i_push_data,
  input wire logic [7:0] i_status_byte,
  input wire logic [7:0] i_rdata,
  output logic [15:0] o_addr,
  output logic o_write,
  output logic [7:0] o_wdata,
  output logic o_opcode_fetch,
  output logic o_busy,
  output logic [15:0] o_pc,
  output logic [7:0] o_sp,
  output logic [7:0] o_pull_data
);

  // ==========================================================================
  // State
  // ==========================================================================
  // Sequencer step, interrupt phase, counter, held target byte, pulled byte
  typedef struct packed {
    sprs_state_type state;
    sprs_irq_type irq;
    logic [15:0] pc;
    logic [7:0] target_low;
    logic [7:0] pull_data;
  } sprs_seq_state_type;

  sprs_seq_state_type state_q;
  sprs_seq_state_type state_d;

  // Stack pointer controls and the page-one stack address
  logic sp_inc;
  logic sp_dec;
  logic sp_load;
  logic [7:0] sp_value;
  logic [15:0] stack_addr;
  // Counter bytes as written onto the stack
  logic [7:0] return_addr_low_byte;
  logic [7:0] return_addr_high_byte;

  // ==========================================================================
  // Stack pointer
  // ==========================================================================
  sprs_stack_pointer u_stack_pointer (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_load(sp_load),
    .i_load_value(i_sp_value),
    .i_inc(sp_inc),
    .i_dec(sp_dec),
    .o_value(sp_value),
    .o_stack_addr(stack_addr)
  );

  // Counter halves as they go onto the stack
  assign return_addr_low_byte = state_q.pc[7:0];
  assign return_addr_high_byte = state_q.pc[15:8];

  // ==========================================================================
  // Next state and bus cycle
  // ==========================================================================
  always_comb
  begin
    state_d = state_q;
    o_addr = state_q.pc;
    o_write = 1'b0;
    o_wdata = 8'h00;
    o_opcode_fetch = 1'b0;
    sp_inc = 1'b0;
    sp_dec = 1'b0;
    sp_load = 1'b0;
    unique case (state_q.state)
      // Idle: an opcode fetch at the counter, except during interrupt entry or a pointer load
      ST_IDLE:
      begin
        if (state_q.irq != IRQ_IDLE)
        begin
          // Interrupt entry pushes counter high, counter low, status
          o_addr = stack_addr;
          o_write = 1'b1;
          sp_dec = 1'b1;
          // High byte first, so it lands at the higher address
          unique case (state_q.irq)
            IRQ_WHIGH:
            begin
              o_wdata = return_addr_high_byte;
              state_d.irq = IRQ_WLOW;
            end
            IRQ_WLOW:
            begin
              o_wdata = return_addr_low_byte;
              state_d.irq = IRQ_WSTAT;
            end
            default:
            begin
              o_wdata = i_status_byte;
              state_d.irq = IRQ_IDLE;
            end
          endcase
        end
        else if (i_irq_entry)
        begin
          // Fetch is dropped and the counter held, so entry saves it intact
          state_d.irq = IRQ_WHIGH;
        end
        else if (i_sp_load)
        begin
          sp_load = 1'b1;
        end
        else
        begin
          o_opcode_fetch = 1'b1;
          if (i_return_op)
          begin
            state_d.pc = state_q.pc + 16'h0001;
            state_d.state = ST_RET_LOOK;
          end
          else if (i_call_subroutine_op)
          begin
            state_d.pc = state_q.pc + 16'h0001;
            state_d.state = ST_CALL_LOW;
          end
          else if (i_push_op)
          begin
            state_d.pc = state_q.pc + 16'h0001;
            state_d.state = ST_PUSH_LOOK;
          end
          else if (i_pull_op)
          begin
            state_d.pc = state_q.pc + 16'h0001;
            state_d.state = ST_PULL_LOOK;
          end
        end
      end
      // Look-ahead read of the next program byte, value dropped
      ST_RET_LOOK:
      begin
        state_d.state = ST_RET_DEAD;
      end
      // Dead stack read while the pointer moves to the first full slot
      ST_RET_DEAD:
      begin
        o_addr = stack_addr;
        sp_inc = 1'b1;
        state_d.state = ST_RET_LOW;
      end
      // First full slot holds the low counter byte
      ST_RET_LOW:
      begin
        o_addr = stack_addr;
        state_d.pc[7:0] = i_rdata;
        sp_inc = 1'b1;
        state_d.state = ST_RET_HIGH;
      end
      // Pointer stays on the high byte's slot, which is now free again
      ST_RET_HIGH:
      begin
        o_addr = stack_addr;
        state_d.pc[15:8] = i_rdata;
        state_d.state = ST_RET_INC;
      end
      // Saved counter names the call's last byte, so step past it
      ST_RET_INC:
      begin
        state_d.pc = state_q.pc + 16'h0001;
        state_d.state = ST_IDLE;
      end
      // Call: fetch target low byte and keep it inside
      ST_CALL_LOW:
      begin
        state_d.target_low = i_rdata;
        state_d.pc = state_q.pc + 16'h0001;
        state_d.state = ST_CALL_DEAD;
      end
      // Dead stack read while the target low byte is held
      ST_CALL_DEAD:
      begin
        o_addr = stack_addr;
        state_d.state = ST_CALL_WHIGH;
      end
      // Counter now names the call's last byte; that is what is saved
      ST_CALL_WHIGH:
      begin
        o_addr = stack_addr;
        o_write = 1'b1;
        o_wdata = return_addr_high_byte;
        sp_dec = 1'b1;
        state_d.state = ST_CALL_WLOW;
      end
      // Low byte goes just below the high byte
      ST_CALL_WLOW:
      begin
        o_addr = stack_addr;
        o_write = 1'b1;
        o_wdata = return_addr_low_byte;
        sp_dec = 1'b1;
        state_d.state = ST_CALL_HIGH;
      end
      // Target high byte read last, so only the low byte needs a holding flop
      ST_CALL_HIGH:
      begin
        state_d.pc = {i_rdata, state_q.target_low};
        state_d.state = ST_IDLE;
      end
      // Push: dropped look-ahead, then write at the free slot
      ST_PUSH_LOOK:
      begin
        state_d.state = ST_PUSH_WR;
      end
      // Pointer already names the free slot, so no dead cycle here
      ST_PUSH_WR:
      begin
        o_addr = stack_addr;
        o_write = 1'b1;
        o_wdata = i_push_data;
        sp_dec = 1'b1;
        state_d.state = ST_IDLE;
      end
      // Pull: extra dead cycle because the pointer names a free slot
      ST_PULL_LOOK:
      begin
        state_d.state = ST_PULL_DEAD;
      end
      // Dead read while the pointer steps onto the full slot
      ST_PULL_DEAD:
      begin
        o_addr = stack_addr;
        sp_inc = 1'b1;
        state_d.state = ST_PULL_RD;
      end
      // Byte read at the slot the pointer now names
      ST_PULL_RD:
      begin
        o_addr = stack_addr;
        state_d.pull_data = i_rdata;
        state_d.state = ST_IDLE;
      end
      // Safe landing for a corrupted state word
      default:
      begin
        state_d.state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Register stage
  // ==========================================================================
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      state_q.state <= ST_IDLE;
      state_q.irq <= IRQ_IDLE;
      state_q.pc <= PC_RESET;
      state_q.target_low <= 8'h00;
      state_q.pull_data <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Status outputs
  // ==========================================================================
  // Straight from flops, so they stand unchanged between updates
  assign o_busy = (state_q.state != ST_IDLE) || (state_q.irq != IRQ_IDLE);
  assign o_pc = state_q.pc;
  assign o_sp = sp_value;
  assign o_pull_data = state_q.pull_data;

endmodule

/* dv/sprs_mem_model.sv */
// Behavioural far-side memory for the sequencer bus
module sprs_mem_model
  import sprs_pkg::*;
(
  input wire logic i_clock,
  input wire logic [15:0] i_addr,
  input wire logic i_write,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] bytes [0:65535];
  // Read/write memory with address bit 8 ignored, so the stack folds onto page zero
  assign o_rdata = bytes[i_addr & 16'hfeff];
  // Write at the end of a write cycle
  always @(posedge i_clock)
    if (i_write)
      bytes[i_addr & 16'hfeff] <= i_wdata;
endmodule

/* dv/sprs_monitor.sv */
// Concurrent checks on the sequencer ports
module sprs_monitor
  import sprs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_return_op,
  input wire logic i_call_subroutine_op,
  input wire logic i_push_op,
  input wire logic i_pull_op,
  input wire logic i_irq_entry,
  input wire logic [7:0] i_push_data,
  input wire logic [7:0] i_rdata,
  input wire logic [15:0] o_addr,
  input wire logic o_write,
  input wire logic [7:0] o_wdata,
  input wire logic o_opcode_fetch,
  input wire logic o_busy,
  input wire logic [7:0] o_sp
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  // ====================
  // Start conditions, priority order kept so no false starts
  // ====================
  logic idle;
  assign idle = o_opcode_fetch && !o_busy;
  sequence ret_go;
    idle && i_return_op;
  endsequence
  sequence call_go;
    idle && i_call_subroutine_op && !i_return_op;
  endsequence
  sequence push_go;
    idle && i_push_op && !i_return_op && !i_call_subroutine_op;
  endsequence
  sequence pull_go;
    idle && i_pull_op && !i_push_op && !i_return_op && !i_call_subroutine_op;
  endsequence
  sequence stk_rd;
    o_addr == {STACK_PAGE, o_sp} && !o_write;
  endsequence
  sequence irq_go;
    i_irq_entry && !o_busy;
  endsequence
  sequence stk_wr;
    o_write && o_addr == {STACK_PAGE, o_sp};
  endsequence
  sequence push_wr;
    stk_wr ##0 o_wdata == i_push_data;
  endsequence
  sequence sp_up;
    o_sp == $past(o_sp) + 8'h01;
  endsequence
  sequence sp_down;
    o_sp == $past(o_sp) - 8'h01;
  endsequence
  // ====================
  // Properties
  // ====================
  a_return_look: assert property (ret_go |=> o_addr == $past(o_addr) + 16'h0001 && !o_write)
    else $error("return look-ahead address wrong");
  a_return_dead: assert property (ret_go |-> ##2 stk_rd)
    else $error("return dead cycle not at stack address");
  a_return_pops: assert property (ret_go |-> ##3 (stk_rd ##0 sp_up) ##1 (stk_rd ##0 sp_up))
    else $error("return pops wrong");
  a_return_pc: assert property (ret_go |-> ##5 (o_addr == {$past(i_rdata), $past(i_rdata, 2)} && !o_write))
    else $error("restored counter not on bus");
  a_return_next: assert property (ret_go |-> ##6 (!o_busy && o_addr == $past(o_addr) + 16'h0001))
    else $error("next fetch address wrong");
  a_return_len: assert property (ret_go |=> o_busy [*5] ##1 !o_busy)
    else $error("return length wrong");
  a_push_write: assert property (push_go |-> ##2 push_wr ##1 sp_down)
    else $error("push write wrong");
  a_pull_order: assert property (pull_go |-> ##2 stk_rd ##1 (stk_rd ##0 sp_up))
    else $error("pull order wrong");
  a_call_stack: assert property (call_go |-> ##3 stk_wr [*2] ##1 (o_sp == $past(o_sp, 3) - 8'h02))
    else $error("call stack use wrong");
  a_irq_stack: assert property (irq_go |=> stk_wr [*3] ##1 (o_sp == $past(o_sp, 4) - 8'h03))
    else $error("interrupt stack use wrong");
  a_write_page: assert property (o_write |-> o_addr[15:8] == STACK_PAGE)
    else $error("write outside the stack page");
endmodule
bind sprs_sequencer sprs_monitor mon (.i_clock, .i_reset, .i_return_op, .i_call_subroutine_op, .i_push_op,
  .i_pull_op, .i_irq_entry, .i_push_data, .i_rdata, .o_addr, .o_write, .o_wdata, .o_opcode_fetch, .o_busy, .o_sp);

/* dv/test_stack_pointer_and_return_sequencer.sv */
// Self-checking bench for the stack pointer and return sequencer
module test_stack_pointer_and_return_sequencer
  import sprs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock, i_reset, i_return_op, i_call_subroutine_op, i_push_op, i_pull_op, i_irq_entry, i_sp_load;
  logic o_write, o_opcode_fetch, o_busy;
  logic [7:0] i_sp_value, i_push_data, i_status_byte, i_rdata, o_wdata, o_sp, o_pull_data;
  logic [15:0] o_addr, o_pc;
  int mismatches, samples_checked;
  // ====================
  // Clock, design and memory
  // ====================
  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  sprs_sequencer uut (.i_clock, .i_reset, .i_return_op, .i_call_subroutine_op, .i_push_op, .i_pull_op,
    .i_irq_entry, .i_sp_load, .i_sp_value, .i_push_data, .i_status_byte, .i_rdata, .o_addr, .o_write,
    .o_wdata, .o_opcode_fetch, .o_busy, .o_pc, .o_sp, .o_pull_data);
  sprs_mem_model memory (.i_clock, .i_addr(o_addr), .i_write(o_write), .i_wdata(o_wdata), .o_rdata(i_rdata));
  // ====================
  // Shared tasks
  // ====================
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One bus cycle, compared mid-cycle; never an opcode fetch
  task automatic cyc(input logic [15:0] a, input logic w);
    @(negedge i_clock);
    check(o_addr, a);
    check({15'h0000, o_write}, {15'h0000, w});
    check({15'h0000, o_opcode_fetch}, 16'h0000);
    @(posedge i_clock);
  endtask
  // Idle cycle: end state of the previous sequence; no fetch while entry or load is asked
  task automatic idle(input logic [15:0] pc, input logic [7:0] sp);
    @(negedge i_clock);
    check(o_addr, pc);
    check(o_pc, pc);
    check({8'h00, o_sp}, {8'h00, sp});
    check({15'h0000, o_busy}, 16'h0000);
    check({15'h0000, o_opcode_fetch}, {15'h0000, ~(i_irq_entry | i_sp_load)});
    @(posedge i_clock);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ====================
  // Scenarios, each starting in the first idle cycle
  // ====================
  // Call from reset state to 0300
  task automatic t_call();
    i_call_subroutine_op <= 1'b1;
    idle(PC_RESET, SP_RESET);
    i_call_subroutine_op <= 1'b0;
    cyc(16'h0001, 1'b0);
    cyc(16'h01ff, 1'b0);
    cyc(16'h01ff, 1'b1);
    cyc(16'h01fe, 1'b1);
    cyc(16'h0002, 1'b0);
    $display("call done");
  endtask
  // Return, back to back with the call
  task automatic t_return();
    i_return_op <= 1'b1;
    idle(16'h0300, 8'hfd);
    i_return_op <= 1'b0;
    cyc(16'h0301, 1'b0);
    cyc(16'h01fd, 1'b0);
    cyc(16'h01fe, 1'b0);
    cyc(16'h01ff, 1'b0);
    cyc(16'h0002, 1'b0);
    check({8'h00, memory.bytes[16'h00fe]}, 16'h0002);
    $display("return done");
  endtask
  // Load pointer to zero, push wraps it to the top
  task automatic t_push_wrap();
    i_sp_load <= 1'b1;
    idle(16'h0003, 8'hff);
    i_sp_load <= 1'b0;
    i_push_op <= 1'b1;
    idle(16'h0003, 8'h00);
    i_push_op <= 1'b0;
    cyc(16'h0004, 1'b0);
    cyc(16'h0100, 1'b1);
    $display("push done");
  endtask
  // Pull wraps the pointer back to zero
  task automatic t_pull_wrap();
    i_pull_op <= 1'b1;
    idle(16'h0004, 8'hff);
    i_pull_op <= 1'b0;
    cyc(16'h0005, 1'b0);
    cyc(16'h01ff, 1'b0);
    cyc(16'h0100, 1'b0);
    $display("pull done");
  endtask
  // Interrupt entry writes three bytes
  task automatic t_irq();
    i_irq_entry <= 1'b1;
    idle(16'h0005, 8'h00);
    i_irq_entry <= 1'b0;
    check({8'h00, o_pull_data}, 16'h00a5);
    cyc(16'h0100, 1'b1);
    cyc(16'h01ff, 1'b1);
    cyc(16'h01fe, 1'b1);
    idle(16'h0005, 8'hfd);
    check({memory.bytes[16'h00ff], memory.bytes[16'h00fe]}, 16'h053c);
    $display("irq done");
  endtask
  // Main sequence; call target preset in memory
  initial
  begin
    {i_return_op, i_call_subroutine_op, i_push_op, i_pull_op, i_irq_entry, i_sp_load} = 6'h00;
    i_sp_value = 8'h00;
    i_push_data = 8'ha5;
    i_status_byte = 8'h3c;
    i_reset = 1'b1;
    mismatches = 0;
    samples_checked = 0;
    memory.bytes[16'h0001] = 8'h00;
    memory.bytes[16'h0002] = 8'h03;
    repeat (10) @(posedge i_clock);
    i_reset <= 1'b0;
    t_call();
    t_return();
    t_push_wrap();
    t_pull_wrap();
    t_irq();
    print_verdict();
  end
  // Watchdog, far beyond the few dozen cycles needed
  initial
  begin
    repeat (1000) @(posedge i_clock);
    mismatches++;
    print_verdict();
  end
endmodule
